// file: qeh_cfg.svh
`ifndef QEH_CFG_SVH
`define QEH_CFG_SVH

// register byte offsets
`define QEH_OFF_CTRL     8'h00
`define QEH_OFF_STATUS   8'h04
`define QEH_OFF_DESC     8'h08
`define QEH_OFF_BUTTONS  8'h0C
`define QEH_OFF_REPORT   8'h10
`define QEH_OFF_AXIS0    8'h20
`define QEH_AXIS_PAGE    3'h1
`define QEH_NUM_CH       3'h6

// control fields
`define QEH_CTRL_VAR_LSB 0
`define QEH_CTRL_SUSP    2
`define QEH_CTRL_BUSRST  3

// reset values
`define QEH_VAR_RST      2'h0
`define QEH_POS_RST      16'h0000
`define QEH_SYNC_RST     30'h00000000
`define QEH_ZERO32       32'h00000000

// channel and button masks per variant
`define QEH_CH_ABS3      6'h07
`define QEH_CH_REL4      6'h0F
`define QEH_CH_REL6      6'h3F
`define QEH_BTN_REL4     7'h7F
`define QEH_BTN_REL6     7'h07

// descriptor values: max power in 2 mA units
`define QEH_MAXPWR_HI    8'hFA
`define QEH_MAXPWR_LO    8'h32
`define QEH_ATTR_BUS     8'h80
`define QEH_CLASS_HID    8'h03
`define QEH_SUBCLASS_GEN 8'h00

// bus constants
`define QEH_HSIZE_WORD   3'h2

`endif

// file: qeh_enc_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side: six quadrature encoders, index sensors, switch contacts, supply gate pin
module qeh_enc_model (
    input  wire logic       clk,
    input  wire logic       gate_oe,
    input  wire logic       gate_out,
    output logic [5:0]      enc_phase_p,
    output logic [5:0]      enc_phase_q,
    output logic [2:0]      index_pulse_ch,
    output logic [6:0]      button_input_n,
    output logic [5:0]      general_input_n,
    output logic            gate_level
);
    logic [1:0] quad_pos [6];

    // pin idles high through its pull-up, follows the device only while it drives
    assign gate_level = gate_oe ? gate_out : 1'b1;

    initial begin
        enc_phase_p = 6'h00;
        enc_phase_q = 6'h00;
        index_pulse_ch = 3'h0;
        button_input_n = 7'h7F;
        general_input_n = 6'h3F;
        for (int i = 0; i < 6; i++) begin
            quad_pos[i] = 2'h0;
        end
    end

    // one quarter step; dir 1 = p leads, 3 = q leads, 2 = both phases at once
    task automatic step(input int ch, input logic [1:0] dir);
        logic [1:0] k;
        k = quad_pos[ch] + dir;
        quad_pos[ch] = k;
        @(posedge clk);
        enc_phase_p[ch] <= k[1] ^ k[0];
        enc_phase_q[ch] <= k[1];
        repeat (3) @(posedge clk);
    endtask

    // index sensor pulse on one channel
    task automatic index_pulse(input int ch);
        @(posedge clk);
        index_pulse_ch[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        index_pulse_ch[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // clean contact levels, bounce already removed outside
    task automatic set_sw(input logic [6:0] b, input logic [5:0] g);
        @(posedge clk);
        button_input_n <= b;
        general_input_n <= g;
    endtask
endmodule

`default_nettype wire

// file: qeh_input_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qeh_cfg.svh"

module qeh_input_top
    import qeh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [5:0]  enc_phase_p,
    input  wire logic [5:0]  enc_phase_q,
    input  wire logic [2:0]  index_pulse_ch,
    input  wire logic [6:0]  button_input_n,
    input  wire logic [5:0]  general_input_n,
    input  wire logic        power_sel,
    input  wire logic        enc_gate_n_in,
    output logic             enc_gate_n_out,
    output logic             enc_gate_n_oe
);
    localparam int PIN_W = 30;

    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    logic [5:0]       ph_p_s;
    logic [5:0]       ph_q_s;
    logic [2:0]       idx_s;
    logic [6:0]       btn_n_s;
    logic [5:0]       gen_n_s;
    logic             pwr_s;
    logic             gate_s;

    logic [2:0]       idx_prev_reg;
    logic [2:0]       idx_rise;
    logic [5:0]       idx_rise6;
    logic [5:0]       step;
    logic [5:0]       up;
    logic [5:0]       ch_en;
    logic [6:0]       btn_act;
    logic             is_abs;
    logic             cnt_run;

    qeh_pos_t         cnt_reg  [6];
    qeh_pos_t         cnt_next [6];
    qeh_pos_t         snap_reg [6];
    qeh_pos_t         snap_next[6];

    qeh_variant_t     var_reg;
    qeh_variant_t     var_next;
    logic             susp_reg;
    logic             susp_next;
    logic             pwr_hi_reg;
    logic             pwr_hi_next;
    qeh_init_t        init_reg;
    qeh_init_t        init_next;
    logic             gate_drv_reg;
    logic             gate_drv_next;

    logic             dp_wr_reg;
    logic             dp_wr_next;
    logic [7:0]       dp_addr_reg;
    logic [7:0]       dp_addr_next;
    logic [31:0]      hrdata_reg;
    logic [31:0]      hrdata_next;
    logic             ap;
    logic             mapped;
    logic [31:0]      rd_val;
    logic             ctrl_wr;
    logic             report_evt;
    logic             busrst_evt;

    // two-stage synchroniser on every pin input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `QEH_SYNC_RST;
            sync2_reg <= `QEH_SYNC_RST;
        end else begin
            sync1_reg <= {enc_gate_n_in, power_sel, general_input_n, button_input_n,
                          index_pulse_ch, enc_phase_q, enc_phase_p};
            sync2_reg <= sync1_reg;
        end
    end

    // split the synchronised pins
    assign ph_p_s  = sync2_reg[5:0];
    assign ph_q_s  = sync2_reg[11:6];
    assign idx_s   = sync2_reg[14:12];
    assign btn_n_s = sync2_reg[21:15];
    assign gen_n_s = sync2_reg[27:22];
    assign pwr_s   = sync2_reg[28];
    assign gate_s  = sync2_reg[29];

    // index edge detect on synchronised levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_prev_reg <= 3'h0;
        end else begin
            idx_prev_reg <= idx_s;
        end
    end

    assign idx_rise  = idx_s & ~idx_prev_reg;
    assign idx_rise6 = {3'h0, idx_rise};
    assign is_abs    = (var_reg == QEH_ABS3);
    // steps only count once the synchronisers hold real pin levels
    assign cnt_run   = (init_reg == QEH_INIT_RUN);

    // active channels per variant
    always_comb begin
        unique case (var_reg)
            QEH_ABS3: ch_en = `QEH_CH_ABS3;
            QEH_REL4: ch_en = `QEH_CH_REL4;
            QEH_REL6: ch_en = `QEH_CH_REL6;
            default:  ch_en = `QEH_CH_REL6;
        endcase
    end

    // live button state, active low pins, no filtering
    always_comb begin
        unique case (var_reg)
            QEH_ABS3: btn_act = {1'b0, ~gen_n_s};
            QEH_REL4: btn_act = ~btn_n_s & `QEH_BTN_REL4;
            QEH_REL6: btn_act = ~btn_n_s & `QEH_BTN_REL6;
            default:  btn_act = ~btn_n_s & `QEH_BTN_REL6;
        endcase
    end

    // per channel decoder, position counter and report snapshot
    for (genvar g = 0; g < 6; g++) begin : g_ch
        qeh_quad_dec u_dec (
            .clk     (clk),
            .rst_n   (rst_n),
            .phase_p (ph_p_s[g]),
            .phase_q (ph_q_s[g]),
            .step    (step[g]),
            .up      (up[g])
        );

        // snapshot on report, then index clear or step
        always_comb begin
            cnt_next[g]  = cnt_reg[g];
            snap_next[g] = snap_reg[g];
            if (report_evt) begin
                snap_next[g] = is_abs ? cnt_reg[g] : {8'h00, cnt_reg[g][7:0]};
                if (!is_abs) begin
                    cnt_next[g] = `QEH_POS_RST;
                end
            end
            if (!ch_en[g]) begin
                cnt_next[g] = `QEH_POS_RST;
            end else if (is_abs && idx_rise6[g]) begin
                cnt_next[g] = `QEH_POS_RST;
            end else if (step[g] && cnt_run && is_abs) begin
                cnt_next[g] = up[g] ? cnt_next[g] + 16'h0001
                                    : cnt_next[g] - 16'h0001;
            end else if (step[g] && cnt_run) begin
                cnt_next[g] = {8'h00, up[g] ? cnt_next[g][7:0] + 8'h01
                                            : cnt_next[g][7:0] - 8'h01};
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_reg[g]  <= `QEH_POS_RST;
                snap_reg[g] <= `QEH_POS_RST;
            end else begin
                cnt_reg[g]  <= cnt_next[g];
                snap_reg[g] <= snap_next[g];
            end
        end
    end

    // bus data-phase decode of writes
    assign ctrl_wr    = dp_wr_reg && (dp_addr_reg == `QEH_OFF_CTRL);
    assign report_evt = dp_wr_reg && (dp_addr_reg == `QEH_OFF_REPORT);
    assign busrst_evt = ctrl_wr && hwdata[`QEH_CTRL_BUSRST];

    // control state, power sampling and supply gate
    always_comb begin
        var_next      = var_reg;
        susp_next     = susp_reg;
        pwr_hi_next   = pwr_hi_reg;
        init_next     = init_reg;
        if (ctrl_wr) begin
            var_next  = qeh_variant_t'(hwdata[`QEH_CTRL_VAR_LSB +: 2]);
            susp_next = hwdata[`QEH_CTRL_SUSP];
        end
        unique case (init_reg)
            QEH_INIT_FILL1:  init_next = QEH_INIT_FILL2;
            QEH_INIT_FILL2:  init_next = QEH_INIT_SAMPLE;
            QEH_INIT_SAMPLE: begin
                init_next   = QEH_INIT_RUN;
                pwr_hi_next = pwr_s;
            end
            QEH_INIT_RUN: begin
                if (busrst_evt) begin
                    pwr_hi_next = pwr_s;
                end
            end
        endcase
        gate_drv_next = (init_next == QEH_INIT_RUN) && !susp_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            var_reg      <= qeh_variant_t'(`QEH_VAR_RST);
            susp_reg     <= 1'b0;
            pwr_hi_reg   <= 1'b0;
            init_reg     <= QEH_INIT_FILL1;
            gate_drv_reg <= 1'b0;
        end else begin
            var_reg      <= var_next;
            susp_reg     <= susp_next;
            pwr_hi_reg   <= pwr_hi_next;
            init_reg     <= init_next;
            gate_drv_reg <= gate_drv_next;
        end
    end

    // open drain gate: only ever pulls low
    assign enc_gate_n_out = 1'b0;
    assign enc_gate_n_oe  = gate_drv_reg;

    // read mux on the address-phase address
    always_comb begin
        rd_val = `QEH_ZERO32;
        if (haddr[7:5] == `QEH_AXIS_PAGE && haddr[4:2] < `QEH_NUM_CH) begin
            rd_val = {16'h0000, snap_reg[haddr[4:2]]};
        end else begin
            unique case (haddr[7:0])
                `QEH_OFF_CTRL:    rd_val = {29'h0, susp_reg, var_reg};
                `QEH_OFF_STATUS:  rd_val = {28'h0, init_reg == QEH_INIT_RUN, gate_s,
                                            susp_reg, pwr_hi_reg};
                `QEH_OFF_DESC:    rd_val = {`QEH_SUBCLASS_GEN, `QEH_CLASS_HID,
                                            `QEH_ATTR_BUS,
                                            pwr_hi_reg ? `QEH_MAXPWR_HI
                                                       : `QEH_MAXPWR_LO};
                `QEH_OFF_BUTTONS: rd_val = {25'h0, btn_act};
                default:          rd_val = `QEH_ZERO32;
            endcase
        end
    end

    // ahb-lite slave, zero wait states
    assign ap     = hsel && hready && htrans[1];
    assign mapped = (haddr[31:8] == 24'h000000);

    always_comb begin
        dp_wr_next   = 1'b0;
        dp_addr_next = dp_addr_reg;
        hrdata_next  = hrdata_reg;
        if (ap) begin
            dp_wr_next   = hwrite && mapped && (hsize == `QEH_HSIZE_WORD);
            dp_addr_next = haddr[7:0];
            if (!hwrite) begin
                hrdata_next = mapped ? rd_val : `QEH_ZERO32;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg  <= `QEH_ZERO32;
        end else begin
            dp_wr_reg   <= dp_wr_next;
            dp_addr_reg <= dp_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // checks
    sequence s_sample_hi;
        init_reg == QEH_INIT_SAMPLE && pwr_s;
    endsequence

    sequence s_sample_lo;
        init_reg == QEH_INIT_SAMPLE && !pwr_s;
    endsequence

    chk_power_high: assert property (@(posedge clk) disable iff (!rst_n)
        s_sample_hi |=> pwr_hi_reg ##1 (hrdata[7:0] == `QEH_MAXPWR_HI || !$past(ap)))
        else $error("high power not taken");

    chk_power_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_sample_lo |=> !pwr_hi_reg)
        else $error("low power not taken");

    chk_power_hold: assert property (@(posedge clk) disable iff (!rst_n)
        init_reg == QEH_INIT_RUN && !busrst_evt |=> $stable(pwr_hi_reg))
        else $error("power class changed outside reset");

    chk_gate_suspend: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && hwdata[`QEH_CTRL_SUSP] |=> !enc_gate_n_oe [*2])
        else $error("gate driven in suspend");

    chk_gate_drive: assert property (@(posedge clk) disable iff (!rst_n)
        init_reg == QEH_INIT_RUN && !susp_reg && !ctrl_wr |=> enc_gate_n_oe)
        else $error("gate not driven while allowed");

    chk_index_clear: assert property (@(posedge clk) disable iff (!rst_n)
        is_abs && idx_rise[0] |=> cnt_reg[0] == `QEH_POS_RST)
        else $error("index did not clear position");

    chk_rel_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !is_abs && report_evt && !step[1] |=> cnt_reg[1] == `QEH_POS_RST)
        else $error("relative count not cleared by report");

    chk_abs_keep: assert property (@(posedge clk) disable iff (!rst_n)
        is_abs && report_evt && !step[0] && !idx_rise[0] |=> $stable(cnt_reg[0]))
        else $error("absolute position lost on report");

    chk_axis_map: assert property (@(posedge clk) disable iff (!rst_n)
        ap && !hwrite && haddr == 32'h00000020 |=> hrdata == {16'h0000, $past(snap_reg[0])})
        else $error("x axis read wrong");

    chk_button_low: assert property (@(posedge clk) disable iff (!rst_n)
        var_reg == QEH_REL4 |-> btn_act == ~btn_n_s)
        else $error("button polarity wrong");

endmodule
`default_nettype wire

// file: qeh_pkg.sv
`default_nettype none

package qeh_pkg;

    // encoder variant chosen by software
    typedef enum logic [1:0] {
        QEH_ABS3,
        QEH_REL4,
        QEH_REL6
    } qeh_variant_t;

    // power-up sequence of the power-class sampler
    typedef enum logic [1:0] {
        QEH_INIT_FILL1,
        QEH_INIT_FILL2,
        QEH_INIT_SAMPLE,
        QEH_INIT_RUN
    } qeh_init_t;

    typedef logic [15:0] qeh_pos_t;

endpackage

`default_nettype wire

// file: qeh_quad_dec.sv
`timescale 1ns/1ps
`default_nettype none

module qeh_quad_dec (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic phase_p,
    input  wire logic phase_q,
    output logic      step,
    output logic      up
);
    logic       seen_reg;
    logic       seen_next;
    logic [1:0] prev_reg;
    logic [1:0] prev_next;
    logic       chg_p;
    logic       chg_q;

    // one step per edge of either phase, none when both move at once
    always_comb begin
        chg_p     = phase_p ^ prev_reg[1];
        chg_q     = phase_q ^ prev_reg[0];
        step      = seen_reg && (chg_p ^ chg_q);
        up        = phase_p ^ prev_reg[0];
        prev_next = {phase_p, phase_q};
        seen_next = 1'b1;
    end

    // first sample after reset only loads the history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 2'h0;
            seen_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            seen_reg <= seen_next;
        end
    end

    chk_fwd_step: assert property (@(posedge clk) disable iff (!rst_n)
        seen_reg && prev_reg == 2'h0 && phase_p && !phase_q |-> step && up)
        else $error("p leading q not counted up");

    chk_both_move: assert property (@(posedge clk) disable iff (!rst_n)
        chg_p && chg_q |-> !step)
        else $error("double change counted");

    chk_one_edge: assert property (@(posedge clk) disable iff (!rst_n)
        seen_reg && (chg_p != chg_q) |-> step)
        else $error("single edge missed");

endmodule
`default_nettype wire

// file: qeh_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qeh_cfg.svh"

module testbench;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    wire logic   hready;
    logic [5:0]  ph_p;
    logic [5:0]  ph_q;
    logic [2:0]  idx;
    logic [6:0]  btn_n;
    logic [5:0]  gen_n;
    logic        power_sel;
    logic        gate_lvl;
    logic        gate_oe;
    logic        gate_out;
    integer      fail_count;
    integer      compares;
    integer      seed;
    int          exp_pos [6];
    logic [31:0] rd;
    logic [31:0] r;

    assign hready = hreadyout;

    qeh_input_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .enc_phase_p(ph_p), .enc_phase_q(ph_q), .index_pulse_ch(idx),
        .button_input_n(btn_n), .general_input_n(gen_n), .power_sel(power_sel),
        .enc_gate_n_in(gate_lvl), .enc_gate_n_out(gate_out), .enc_gate_n_oe(gate_oe));

    qeh_enc_model i_enc (.clk(clk), .gate_oe(gate_oe), .gate_out(gate_out),
        .enc_phase_p(ph_p), .enc_phase_q(ph_q), .index_pulse_ch(idx), .button_input_n(btn_n),
        .general_input_n(gen_n), .gate_level(gate_lvl));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // single word read, two bus phases
    task bus_rd(input logic [7:0] a);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // single word write
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask

    // expected axis word for one channel in one variant
    function automatic logic [31:0] axis_exp(input int ch, input logic [1:0] v);
        if (v == 2'h0) return (ch < 3) ? {16'h0000, exp_pos[ch][15:0]} : 32'h0;
        if (v == 2'h1 && ch > 3) return 32'h0;
        return {24'h000000, exp_pos[ch][7:0]};
    endfunction

    task move(input int ch, input int n);
        for (int i = 0; i < ((n < 0) ? -n : n); i++) begin
            i_enc.step(ch, (n < 0) ? 2'h3 : 2'h1);
        end
        exp_pos[ch] += n;
    endtask

    // send a report and compare all six axes
    task check_axes(input logic [1:0] v);
        repeat (4) @(posedge clk);
        bus_wr(`QEH_OFF_REPORT, 32'h0);
        for (int ch = 0; ch < 6; ch++) begin
            bus_rd(`QEH_OFF_AXIS0 + 8'(4 * ch));
            chk("axis", axis_exp(ch, v), rd);
        end
        // relative counts restart; disabled absolute channels stay at zero
        for (int ch = 0; ch < 6; ch++) if (v != 2'h0 || ch > 2) exp_pos[ch] = 0;
    endtask

    task sw_check(input logic [1:0] v);
        logic [31:0] b;
        logic [31:0] g;
        logic [31:0] e;
        b = $random(seed);
        g = $random(seed);
        i_enc.set_sw(b[6:0], g[5:0]);
        repeat (4) @(posedge clk);
        bus_rd(`QEH_OFF_BUTTONS);
        e = (v == 2'h0) ? {26'h0, ~g[5:0]} : (v == 2'h1) ? {25'h0, ~b[6:0]}
            : {29'h0, ~b[2:0]};
        chk("buttons", e, rd);
    endtask

    // main sequence
    initial begin
        seed = 24154;
        fail_count = 0;
        compares = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        power_sel = 1'b1;
        for (int i = 0; i < 6; i++) exp_pos[i] = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rd(`QEH_OFF_STATUS);
        chk("status", 32'h9, rd & 32'hF);
        chk("hresp", 32'h0, {31'h0, hresp});
        bus_rd(`QEH_OFF_DESC);
        chk("desc", {`QEH_SUBCLASS_GEN, `QEH_CLASS_HID, `QEH_ATTR_BUS, `QEH_MAXPWR_HI}, rd);
        chk("gate_oe", 32'h1, {31'h0, gate_oe});
        power_sel <= 1'b0;
        repeat (4) @(posedge clk);
        bus_rd(`QEH_OFF_DESC);
        chk("desc_pwr", {24'h0, `QEH_MAXPWR_HI}, rd & 32'hFF);
        bus_wr(`QEH_OFF_CTRL, 32'h8);
        repeat (6) @(posedge clk);
        bus_rd(`QEH_OFF_DESC);
        chk("desc_pwr", {24'h0, `QEH_MAXPWR_LO}, rd & 32'hFF);
        // absolute variant
        for (int ch = 0; ch < 4; ch++) move(ch, $random(seed) % 24);
        move(1, -3);
        check_axes(2'h0);
        i_enc.step(1, 2'h2);
        i_enc.index_pulse(2);
        exp_pos[2] = 0;
        i_enc.index_pulse(0);
        exp_pos[0] = 0;
        check_axes(2'h0);
        sw_check(2'h0);
        // relative variants, counters cleared by each report
        for (int v = 1; v < 3; v++) begin
            bus_wr(`QEH_OFF_CTRL, 32'(v));
            check_axes(2'(v));
            for (int ch = 0; ch < 6; ch++) move(ch, $random(seed) % 24);
            if (v == 1) move(0, 260);
            check_axes(2'(v));
            check_axes(2'(v));
            sw_check(2'(v));
        end
        // suspend releases the supply gate
        bus_wr(`QEH_OFF_CTRL, 32'h6);
        repeat (4) @(posedge clk);
        chk("gate_oe", 32'h0, {31'h0, gate_oe});
        bus_rd(`QEH_OFF_STATUS);
        chk("status_susp", 32'h6, rd & 32'h6);
        bus_wr(`QEH_OFF_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        chk("gate_oe", 32'h1, {31'h0, gate_oe});
        // unmapped offset
        r = $random(seed);
        bus_wr(8'h40, r);
        bus_rd(8'h40);
        chk("unmapped", 32'h0, rd);
        // reset in mid-run with the power select low
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rd(`QEH_OFF_DESC);
        chk("desc_rst", {24'h0, `QEH_MAXPWR_LO}, rd & 32'hFF);
        end_sim;
    end

    // watchdog
    initial begin
        #2000000;
        fail_count++;
        $display("watchdog expired");
        end_sim;
    end
endmodule

`default_nettype wire
